// ---- hw/rtc_pkg.sv ----
// Shared constants and types for the real-time counter
package rtc_pkg;
  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [5:0] IDX_CTRL     = 6'h00;
  localparam logic [5:0] IDX_STATUS   = 6'h01;
  localparam logic [5:0] IDX_LEVELS   = 6'h02;
  localparam logic [5:0] IDX_FLAGS    = 6'h03;
  localparam logic [5:0] IDX_CNT      = 6'h08;
  localparam logic [5:0] IDX_PER      = 6'h0A;
  localparam logic [5:0] IDX_COMP     = 6'h0C;
  localparam logic [5:0] IDX_IRQCLR   = 6'h10;
  // ----------------------------------------
  // Field positions and widths
  // ----------------------------------------
  localparam int PRESC_W     = 3;
  localparam int BUSY_BIT    = 0;
  localparam int OVF_LVL_LSB = 0;
  localparam int CMP_LVL_LSB = 2;
  localparam int OVF_BIT     = 0;
  localparam int CMP_BIT     = 1;
  // Pending-update mask bits
  localparam int PD_CTRL = 0;
  localparam int PD_CNT  = 1;
  localparam int PD_PER  = 2;
  localparam int PD_COMP = 3;
  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [2:0]  CTRL_RST  = 3'h0;
  localparam logic [3:0]  INTC_RST  = 4'h0;
  localparam logic [15:0] PER_RST   = 16'hFFFF;
  localparam logic [15:0] COMP_RST  = 16'h0000;
  localparam logic [15:0] CNT_RST   = 16'h0000;
  localparam logic [1:0]  SYNC_REFS = 2'h2;
  // Prescale codes
  localparam logic [2:0] PS_OFF  = 3'h0;
  localparam logic [2:0] PS_D1   = 3'h1;
  localparam logic [2:0] PS_D2   = 3'h2;
  localparam logic [2:0] PS_D8   = 3'h3;
  localparam logic [2:0] PS_D16  = 3'h4;
  localparam logic [2:0] PS_D64  = 3'h5;
  localparam logic [2:0] PS_D256 = 3'h6;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Interrupt level group toward the interrupt controller
  typedef struct packed {
    logic [1:0] cmp_lvl;
    logic [1:0] ovf_lvl;
  } rtc_irq_t;
endpackage

// ---- hw/rtc_top.sv ----
// Real-time counter with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
// Function
// (R01) A 16-bit counter advances on the prescaled reference clock and may wake or interrupt.
// (R02) Prescale code 0 stops the counter and codes 1 to 7 divide by 1, 2, 8, 16, 64, 256, 1024.
// (R03) The tick after count equals compare raises the compare flag and event.
// (R04) The tick after count equals period raises the overflow flag and event.
// (R05) The overflow reloads the count with zero.
// (R06) Events fire only every third match at period zero and every second at period one.
// (R07) With period two or more every match gives an event.
// (R08) Writes reach the counter only after synchronising to the reference clock.
// (R09) Status bit 0 shows busy while a count, control, period or compare update crosses.
// (R10) Compare level field at bits 3:2 enables the compare request while its flag is set.
// (R11) Software writes zero to reserved bits.
// (R12) Overflow level field at bits 1:0 enables the overflow request while its flag is set.
// (R13) Flags set on the tick after their condition and clear on vector or write of one.
// (R14) Software waits for busy clear before writing; updates act two reference edges later.
// (R15) A compare value above the period never gives a compare request or event.
// (R16) A level of zero keeps the request low; nonzero forwards it at that level.
// (R17) After reset the prescaler is off and both levels are disabled.
module rtc_top #(
  parameter int CNT_W  = 16,
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // Reference clock, sampled as a level
  input  wire logic              ref_clk_in,
  // AXI4-Lite write
  input  wire logic              awvalid_in,
  output logic                   awready_out,
  input  wire logic [ADDR_W-1:0] awaddr_in,
  input  wire logic              wvalid_in,
  output logic                   wready_out,
  input  wire logic [31:0]       wdata_in,
  input  wire logic [3:0]        wstrb_in,
  output logic                   bvalid_out,
  input  wire logic              bready_in,
  output logic [1:0]             bresp_out,
  // AXI4-Lite read
  input  wire logic              arvalid_in,
  output logic                   arready_out,
  input  wire logic [ADDR_W-1:0] araddr_in,
  output logic                   rvalid_out,
  input  wire logic              rready_in,
  output logic [31:0]            rdata_out,
  output logic [1:0]             rresp_out,
  // Vector execution acknowledges
  input  wire logic              cmp_vec_ack_in,
  input  wire logic              ovf_vec_ack_in,
  // Interrupts, events, wake
  output rtc_pkg::rtc_irq_t      irq_lvl_out,
  output logic                   irq_out,
  output logic                   wake_out,
  output logic                   cmp_event_out,
  output logic                   ovf_event_out
);
  import rtc_pkg::*;

  // Index decode reads address bits 7:2, so narrower buses cannot work
  if (CNT_W != 16 || ADDR_W < 8) begin : g_bad_param
    $error("rtc_top: unsupported CNT_W or ADDR_W");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic              aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
  logic [5:0]        awidx_ff;
  logic [31:0]       wdata_ff, rdata_ff;
  logic [3:0]        wstrb_ff;
  logic [1:0]        bresp_ff, rresp_ff;
  logic              wr_go, rd_go;
  logic [5:0]        rd_idx;
  logic [2:0]        ctrl_sh_ff, ctrl_ff;
  logic [CNT_W-1:0]  cnt_sh_ff, per_sh_ff, comp_sh_ff;
  logic [CNT_W-1:0]  cnt_ff, per_ff, comp_ff;
  logic [3:0]        intc_ff;
  logic [3:0]        pend_ff;
  logic [1:0]        sync_cnt_ff;
  logic              ref_d_ff, ref_rise, apply;
  logic [9:0]        pcnt_ff, pmask;
  logic              tick, ovf_hit, cmp_hit;
  logic [1:0]        flags_ff, clr_w1;
  logic [1:0]        hit, fire;
  logic [1:0]        ev_ph_ff [2];
  logic [1:0]        ev_ff;

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  assign awready_out = !aw_hold_ff && !bvalid_ff;
  assign wready_out  = !w_hold_ff && !bvalid_ff;
  assign wr_go       = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign bvalid_out  = bvalid_ff;
  assign bresp_out   = bresp_ff;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_hold_ff <= 1'b0;
      awidx_ff   <= 6'h00;
    end else if (awvalid_in && awready_out) begin
      aw_hold_ff <= 1'b1;
      awidx_ff   <= awaddr_in[7:2];
    end else if (wr_go) begin
      aw_hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      w_hold_ff <= 1'b0;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
    end else if (wvalid_in && wready_out) begin
      w_hold_ff <= 1'b1;
      wdata_ff  <= wdata_in;
      wstrb_ff  <= wstrb_in;
    end else if (wr_go) begin
      w_hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OK;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      case (awidx_ff)
        IDX_CTRL, IDX_STATUS, IDX_LEVELS, IDX_FLAGS,
        IDX_CNT, IDX_PER, IDX_COMP, IDX_IRQCLR: bresp_ff <= RESP_OK;
        default: bresp_ff <= RESP_ERR;
      endcase
    end else if (bready_in) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Shadow registers, written at bus speed
  // ----------------------------------------
  // (R17) prescaler off, levels zero after reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_sh_ff <= CTRL_RST;
      intc_ff    <= INTC_RST;
      cnt_sh_ff  <= CNT_RST;
      per_sh_ff  <= PER_RST;
      comp_sh_ff <= COMP_RST;
    end else if (wr_go && wstrb_ff[0]) begin
      case (awidx_ff)
        IDX_CTRL:    ctrl_sh_ff <= wdata_ff[PRESC_W-1:0];
        IDX_LEVELS:  intc_ff    <= wdata_ff[3:0];
        IDX_CNT:     cnt_sh_ff[7:0]  <= wdata_ff[7:0];
        IDX_PER:     per_sh_ff[7:0]  <= wdata_ff[7:0];
        IDX_COMP:    comp_sh_ff[7:0] <= wdata_ff[7:0];
        default: ;
      endcase
      if (wstrb_ff[1]) begin
        case (awidx_ff)
          IDX_CNT:  cnt_sh_ff[15:8]  <= wdata_ff[15:8];
          IDX_PER:  per_sh_ff[15:8]  <= wdata_ff[15:8];
          IDX_COMP: comp_sh_ff[15:8] <= wdata_ff[15:8];
          default: ;
        endcase
      end
    end else if (wr_go && wstrb_ff[1]) begin
      case (awidx_ff)
        IDX_CNT:  cnt_sh_ff[15:8]  <= wdata_ff[15:8];
        IDX_PER:  per_sh_ff[15:8]  <= wdata_ff[15:8];
        IDX_COMP: comp_sh_ff[15:8] <= wdata_ff[15:8];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Domain crossing of updates
  // ----------------------------------------
  assign ref_rise = ref_clk_in && !ref_d_ff;
  assign apply    = (pend_ff != 4'h0) && ref_rise && (sync_cnt_ff == SYNC_REFS - 2'h1);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ref_d_ff <= 1'b0;
    end else begin
      ref_d_ff <= ref_clk_in;
    end
  end

  // (R09) busy while any update waits
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_ff     <= 4'h0;
      sync_cnt_ff <= 2'h0;
    end else if (wr_go && (awidx_ff == IDX_CTRL || awidx_ff == IDX_CNT ||
                           awidx_ff == IDX_PER || awidx_ff == IDX_COMP)) begin
      // A fresh write restarts the crossing
      // Bits applied in this same cycle must not load a second time
      pend_ff[PD_CTRL] <= (pend_ff[PD_CTRL] && !apply) || (awidx_ff == IDX_CTRL);
      pend_ff[PD_CNT]  <= (pend_ff[PD_CNT] && !apply) || (awidx_ff == IDX_CNT);
      pend_ff[PD_PER]  <= (pend_ff[PD_PER] && !apply) || (awidx_ff == IDX_PER);
      pend_ff[PD_COMP] <= (pend_ff[PD_COMP] && !apply) || (awidx_ff == IDX_COMP);
      sync_cnt_ff      <= 2'h0;
    end else if (apply) begin
      pend_ff     <= 4'h0;
      sync_cnt_ff <= 2'h0;
    end else if (pend_ff != 4'h0 && ref_rise) begin
      sync_cnt_ff <= sync_cnt_ff + 2'h1;
    end
  end

  // (R08) live values load only after the crossing
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_ff <= CTRL_RST;
      per_ff  <= PER_RST;
      comp_ff <= COMP_RST;
    end else if (apply) begin
      if (pend_ff[PD_CTRL]) ctrl_ff <= ctrl_sh_ff;
      if (pend_ff[PD_PER])  per_ff  <= per_sh_ff;
      if (pend_ff[PD_COMP]) comp_ff <= comp_sh_ff;
    end
  end

  // ----------------------------------------
  // Prescaler and counter
  // ----------------------------------------
  // (R02) divisor mask per prescale code
  always_comb begin
    case (ctrl_ff)
      PS_D1:   pmask = 10'h000;
      PS_D2:   pmask = 10'h001;
      PS_D8:   pmask = 10'h007;
      PS_D16:  pmask = 10'h00F;
      PS_D64:  pmask = 10'h03F;
      PS_D256: pmask = 10'h0FF;
      default: pmask = 10'h3FF;
    endcase
  end

  assign tick    = ref_rise && (ctrl_ff != PS_OFF) && ((pcnt_ff & pmask) == pmask);
  assign ovf_hit = tick && (cnt_ff == per_ff);
  // (R15) compare above period is never a match
  assign cmp_hit = tick && (cnt_ff == comp_ff) && (comp_ff <= per_ff);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pcnt_ff <= 10'h000;
    end else if (ctrl_ff == PS_OFF) begin
      pcnt_ff <= 10'h000;
    end else if (ref_rise) begin
      pcnt_ff <= pcnt_ff + 10'h001;
    end
  end

  // (R01) count on each prescaled tick
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_ff <= CNT_RST;
    end else if (apply && pend_ff[PD_CNT]) begin
      cnt_ff <= cnt_sh_ff;
    end else if (ovf_hit) begin
      // (R05) wrap to zero
      cnt_ff <= CNT_RST;
    end else if (tick) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  // ----------------------------------------
  // Flags and interrupt requests
  // ----------------------------------------
  assign clr_w1 = (wr_go && wstrb_ff[0] &&
                   (awidx_ff == IDX_FLAGS || awidx_ff == IDX_IRQCLR)) ?
                  wdata_ff[1:0] : 2'h0;

  // (R13) set beats clear in the same cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_ff <= 2'h0;
    end else begin
      flags_ff[OVF_BIT] <= ovf_hit ||
        (flags_ff[OVF_BIT] && !clr_w1[OVF_BIT] && !ovf_vec_ack_in);
      // (R03) compare flag
      flags_ff[CMP_BIT] <= cmp_hit ||
        (flags_ff[CMP_BIT] && !clr_w1[CMP_BIT] && !cmp_vec_ack_in);
    end
  end

  // (R10) compare level gated by its flag
  assign irq_lvl_out.cmp_lvl = flags_ff[CMP_BIT] ? intc_ff[CMP_LVL_LSB +: 2] : 2'h0;
  // (R12) overflow level gated by its flag
  assign irq_lvl_out.ovf_lvl = flags_ff[OVF_BIT] ? intc_ff[OVF_LVL_LSB +: 2] : 2'h0;
  // (R16) level zero keeps the request low
  assign irq_out  = (irq_lvl_out.cmp_lvl != 2'h0) || (irq_lvl_out.ovf_lvl != 2'h0);
  assign wake_out = irq_out;

  // ----------------------------------------
  // Event decimation
  // ----------------------------------------
  // Events cross to the event fabric slowly, hence skipping at tiny periods
  assign hit = {cmp_hit, ovf_hit};
  for (genvar g = 0; g < 2; g++) begin : g_ev
    // (R06) every third at period 0, every second at period 1
    always_comb begin
      case (per_ff)
        16'h0000: fire[g] = hit[g] && (ev_ph_ff[g] == 2'h2);
        16'h0001: fire[g] = hit[g] && (ev_ph_ff[g] == 2'h1);
        // (R07) every match otherwise
        default:  fire[g] = hit[g];
      endcase
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        ev_ph_ff[g] <= 2'h0;
      end else if (fire[g] || per_ff > 16'h0001) begin
        ev_ph_ff[g] <= 2'h0;
      end else if (hit[g]) begin
        ev_ph_ff[g] <= ev_ph_ff[g] + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ev_ff <= 2'h0;
    end else begin
      ev_ff <= fire;
    end
  end
  // (R04) overflow event with its flag
  assign ovf_event_out = ev_ff[0];
  assign cmp_event_out = ev_ff[1];

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  assign arready_out = !rvalid_ff;
  assign rd_go       = arvalid_in && arready_out;
  assign rd_idx      = araddr_in[7:2];
  assign rvalid_out  = rvalid_ff;
  assign rdata_out   = rdata_ff;
  assign rresp_out   = rresp_ff;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OK;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= RESP_OK;
      rdata_ff  <= 32'h0000_0000;
      case (rd_idx)
        IDX_CTRL:     rdata_ff[2:0]  <= ctrl_sh_ff;
        IDX_STATUS:   rdata_ff[BUSY_BIT] <= (pend_ff != 4'h0);
        IDX_LEVELS:   rdata_ff[3:0]  <= intc_ff;
        IDX_FLAGS:    rdata_ff[1:0]  <= flags_ff;
        IDX_CNT:      rdata_ff[15:0] <= cnt_ff;
        IDX_PER:      rdata_ff[15:0] <= per_sh_ff;
        IDX_COMP:     rdata_ff[15:0] <= comp_sh_ff;
        IDX_IRQCLR:   ;
        default:      rresp_ff <= RESP_ERR;
      endcase
    end else if (rready_in) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  stop_no_tick_a: assert property (ctrl_ff == PS_OFF && !apply // (R02)
    |=> cnt_ff == $past(cnt_ff))
    else $error("tick while stopped");
  wrap_zero_a: assert property (ovf_hit && !(apply && pend_ff[PD_CNT]) // (R05)
    |=> cnt_ff == 16'h0000)
    else $error("count did not wrap");
  ovf_flag_a: assert property (tick && cnt_ff == per_ff |=> flags_ff[OVF_BIT]) // (R04)
    else $error("overflow flag missing");
  cmp_flag_a: assert property (tick && cnt_ff == comp_ff && comp_ff <= per_ff
    |=> flags_ff[CMP_BIT]) // (R03)
    else $error("compare flag missing");
  cmp_above_a: assert property (tick && comp_ff > per_ff |=> !cmp_event_out) // (R15)
    else $error("compare event above period");
  ev_every_a: assert property (ovf_hit && per_ff > 16'h0001 |=> ovf_event_out) // (R07)
    else $error("overflow event dropped");
  ev_decim_a: assert property (ovf_hit && per_ff == 16'h0000 && ev_ph_ff[0] != 2'h2
    |=> !ovf_event_out) // (R06)
    else $error("event not decimated");
  busy_set_a: assert property (wr_go && awidx_ff == IDX_CNT |=> pend_ff != 4'h0) // (R09)
    else $error("busy not set");
  busy_clr_a: assert property (apply && !wr_go |=> pend_ff == 4'h0) // (R09)
    else $error("busy not cleared");
  lvl_gate_a: assert property (irq_out |-> (flags_ff[CMP_BIT] && intc_ff[3:2] != 2'h0) ||
    (flags_ff[OVF_BIT] && intc_ff[1:0] != 2'h0)) // (R16)
    else $error("request without enabled flag");
  rst_state_a: assert property ($fell(rst_in) |-> ctrl_ff == PS_OFF && intc_ff == 4'h0) // (R17)
    else $error("reset state wrong");
  cov_wrap_c: cover property (ovf_hit ##1 ovf_event_out);
  cov_cmp_c:  cover property (cmp_hit ##1 irq_out);
  cov_sync_c: cover property (wr_go ##[1:200] apply);
endmodule
`default_nettype wire

// ---- verif/rtc_host_model.sv ----
// Interrupt controller and event system model facing the real-time counter
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // Counter side
  input  wire rtc_pkg::rtc_irq_t irq_lvl_in,
  input  wire logic              cmp_event_in,
  input  wire logic              ovf_event_in,
  output logic                   cmp_vec_ack_out,
  output logic                   ovf_vec_ack_out,
  // Bench side
  input  wire logic              ack_en_in,
  input  wire logic              ack_slow_in,
  input  wire logic              ev_clr_in,
  output logic [15:0]            cmp_events_out,
  output logic [15:0]            ovf_events_out
);
  import rtc_pkg::*;
  logic [3:0] wait_ff;
  logic       pend;
  assign pend = ack_en_in && (irq_lvl_in != 4'h0) && !cmp_vec_ack_out && !ovf_vec_ack_out;
  // ----------------------------------------
  // Vector execution
  // ----------------------------------------
  // vector runs only for a nonzero level
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_ff         <= 4'h0;
      cmp_vec_ack_out <= 1'b0;
      ovf_vec_ack_out <= 1'b0;
    end else begin
      cmp_vec_ack_out <= 1'b0;
      ovf_vec_ack_out <= 1'b0;
      if (!pend) begin
        wait_ff <= 4'h0;
      end else if (wait_ff != (ack_slow_in ? 4'h6 : 4'h0)) begin
        wait_ff <= wait_ff + 4'h1;
      end else begin
        wait_ff <= 4'h0;
        // Compare first, as the higher level in this bench
        if (irq_lvl_in.cmp_lvl != 2'h0) cmp_vec_ack_out <= 1'b1;
        else ovf_vec_ack_out <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // Event counting
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in || ev_clr_in) begin
      cmp_events_out <= 16'h0000;
      ovf_events_out <= 16'h0000;
    end else begin
      cmp_events_out <= cmp_events_out + {15'h0000, cmp_event_in};
      ovf_events_out <= ovf_events_out + {15'h0000, ovf_event_in};
    end
  end
endmodule
`default_nettype wire

// ---- verif/real_time_counter_test.sv ----
// Self-checking bench for the real-time counter
`timescale 1ns/1ps
`default_nettype none
module real_time_counter_test;
  import rtc_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        ref_clk = 1'b0;
  logic [2:0]  refdiv = 3'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        ack_en = 1'b0, ack_slow = 1'b0, ev_clr = 1'b0;
  wire logic   awready, wready, bvalid, arready, rvalid, irq, wake, cmp_ev, ovf_ev;
  wire logic   cmp_ack, ovf_ack;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [15:0] cmp_n, ovf_n;
  rtc_irq_t    irq_lvl;
  int          failures = 0;
  int          comparisons = 0;
  logic [31:0] rd, c0, c1;
  logic [1:0]  rs;
  // Reset table and prescale rows
  logic [5:0]  ri [9] = '{IDX_CTRL, IDX_STATUS, IDX_LEVELS, IDX_FLAGS, IDX_CNT,
                          IDX_PER, IDX_COMP, IDX_IRQCLR, 6'h05};
  logic [31:0] re [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0};
  logic [2:0]  pc [8] = '{PS_OFF, PS_D1, PS_D2, PS_D8, PS_D16, PS_D64, PS_D256, 3'h7};
  int          pn [8] = '{32, 32, 32, 32, 32, 64, 64, 64};
  int          pe [8] = '{0, 32, 16, 4, 2, 1, 0, 0};
  logic [31:0] pv [3] = '{32'h0, 32'h1, 32'h3};
  int          ve [3] = '{16, 12, 12};
  initial forever #5 clk_in = ~clk_in;
  // Free-running reference, eight system clocks a period
  always @(posedge clk_in) begin
    refdiv <= refdiv + 3'h1;
    if (refdiv == 3'h3 || refdiv == 3'h7) ref_clk <= ~ref_clk;
  end
  rtc_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .ref_clk_in(ref_clk),
    .awvalid_in(awvalid), .awready_out(awready), .awaddr_in(awaddr), .wvalid_in(wvalid),
    .wready_out(wready), .wdata_in(wdata), .wstrb_in(wstrb), .bvalid_out(bvalid),
    .bready_in(bready), .bresp_out(bresp), .arvalid_in(arvalid), .arready_out(arready),
    .araddr_in(araddr), .rvalid_out(rvalid), .rready_in(rready), .rdata_out(rdata),
    .rresp_out(rresp), .cmp_vec_ack_in(cmp_ack), .ovf_vec_ack_in(ovf_ack),
    .irq_lvl_out(irq_lvl), .irq_out(irq), .wake_out(wake), .cmp_event_out(cmp_ev),
    .ovf_event_out(ovf_ev));
  rtc_host_model host_u (.clk_in(clk_in), .rst_in(rst_in), .irq_lvl_in(irq_lvl),
    .cmp_event_in(cmp_ev), .ovf_event_in(ovf_ev), .cmp_vec_ack_out(cmp_ack),
    .ovf_vec_ack_out(ovf_ack), .ack_en_in(ack_en), .ack_slow_in(ack_slow),
    .ev_clr_in(ev_clr), .cmp_events_out(cmp_n), .ovf_events_out(ovf_n));
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic end_of_test;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    comparisons++;
    if (^got === 1'bx || got < lo || got > hi) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic hang;
    failures++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end_of_test();
  endtask
  // ----------------------------------------
  // Register bus master
  // ----------------------------------------
  task automatic wr(input logic [5:0] idx, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic a_p, w_p;
    @(posedge clk_in);
    awvalid <= 1'b1;
    awaddr <= {idx, 2'h0};
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    a_p = 1'b1;
    w_p = 1'b1;
    n = 0;
    while ((a_p || w_p) && n < 100) begin
      @(posedge clk_in);
      n++;
      if (a_p && awready === 1'b1) begin awvalid <= 1'b0; a_p = 1'b0; end
      if (w_p && wready === 1'b1) begin wvalid <= 1'b0; w_p = 1'b0; end
    end
    bready <= 1'b1;
    do begin @(posedge clk_in); n++; end while (bvalid !== 1'b1 && n < 200);
    r = bresp;
    bready <= 1'b0;
    if (n >= 200) hang();
  endtask
  task automatic rdr(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_in);
    arvalid <= 1'b1;
    araddr <= {idx, 2'h0};
    n = 0;
    do begin @(posedge clk_in); n++; end while (arready !== 1'b1 && n < 100);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin @(posedge clk_in); n++; end while (rvalid !== 1'b1 && n < 200);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 200) hang();
  endtask
  // Poll until no update is crossing
  task automatic wait_idle;
    int n;
    logic [31:0] s;
    logic [1:0] q;
    n = 0;
    do begin rdr(IDX_STATUS, s, q); n++; end while (s[BUSY_BIT] !== 1'b0 && n < 50);
    if (n >= 50) hang();
  endtask
  // Write only once idle, then wait for the crossing to finish
  task automatic wrs(input logic [5:0] idx, input logic [31:0] d);
    logic [1:0] q;
    wait_idle();
    wr(idx, d, q);
    wait_idle();
  endtask
  task automatic ref_edges(input int k);
    int n;
    logic p;
    n = 0;
    p = ref_clk;
    while (n < k) begin
      @(posedge clk_in);
      if (ref_clk && !p) n++;
      p = ref_clk;
    end
  endtask
  task automatic clear_events;
    @(posedge clk_in);
    ev_clr <= 1'b1;
    @(posedge clk_in);
    ev_clr <= 1'b0;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rdr(ri[i], rd, rs);
      chk(rd, re[i]);
    end
    chk({30'h0, rs}, {30'h0, RESP_ERR});
    chk({31'h0, irq}, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wrs(IDX_CTRL, 32'h0);
      wrs(IDX_CNT, 32'h0);
      wrs(IDX_CTRL, {29'h0, pc[i]});
      rdr(IDX_CNT, c0, rs);
      ref_edges(pn[i]);
      rdr(IDX_CNT, c1, rs);
      chk_rng(c1 - c0, pe[i] - (pe[i] > 0), pe[i] + (pc[i] != 3'h0));
    end
    $display("test prescale done");
    wr(IDX_PER, 32'h3, rs);
    rdr(IDX_STATUS, rd, rs);
    chk(rd, 32'h1);
    wrs(IDX_COMP, 32'h1);
    wr(IDX_STATUS, 32'h1, rs);
    chk({30'h0, rs}, {30'h0, RESP_OK});
    rdr(IDX_STATUS, rd, rs);
    chk(rd, 32'h0);
    $display("test busy done");
    wrs(IDX_CNT, 32'h0);
    wrs(IDX_CTRL, {29'h0, PS_D1});
    ref_edges(10);
    wrs(IDX_CTRL, 32'h0);
    rdr(IDX_FLAGS, rd, rs);
    chk(rd, 32'h3);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_LEVELS, 32'h9, rs);
    chk({28'h0, irq_lvl}, 32'h9);
    chk({30'h0, wake, irq}, 32'h3);
    wr(IDX_IRQCLR, 32'h1, rs);
    chk({28'h0, irq_lvl}, 32'h8);
    @(posedge clk_in);
    ack_slow <= 1'b1;
    ack_en <= 1'b1;
    for (int n = 0; n < 40 && irq !== 1'b0; n++) @(posedge clk_in);
    chk({31'h0, irq}, 32'h0);
    rdr(IDX_FLAGS, rd, rs);
    chk(rd, 32'h0);
    ack_en <= 1'b0;
    wr(IDX_LEVELS, 32'h0, rs);
    $display("test interrupt done");
    for (int j = 0; j < 3; j++) begin
      wrs(IDX_CTRL, 32'h0);
      wrs(IDX_CNT, 32'h0);
      wrs(IDX_PER, pv[j]);
      wrs(IDX_COMP, 32'h0);
      wrs(IDX_CTRL, {29'h0, PS_D1});
      clear_events();
      ref_edges(48);
      chk_rng({16'h0, ovf_n}, ve[j] - 1, ve[j] + 1);
      chk_rng({16'h0, cmp_n}, ve[j] - 1, ve[j] + 1);
      rdr(IDX_CNT, rd, rs);
      chk_rng(rd, 0, pv[j]);
    end
    $display("test events done");
    wrs(IDX_COMP, 32'h5);
    wr(IDX_IRQCLR, 32'h3, rs);
    clear_events();
    ref_edges(24);
    chk({16'h0, cmp_n}, 32'h0);
    rdr(IDX_FLAGS, rd, rs);
    chk(rd, 32'h1);
    // Overflow vector alone clears its flag
    wrs(IDX_CTRL, 32'h0);
    wr(IDX_LEVELS, 32'h1, rs);
    chk({28'h0, irq_lvl}, 32'h1);
    ack_en <= 1'b1;
    for (int n = 0; n < 40 && irq !== 1'b0; n++) @(posedge clk_in);
    rdr(IDX_FLAGS, rd, rs);
    chk(rd, 32'h0);
    $display("test compare above period done");
    end_of_test();
  end
endmodule
`default_nettype wire
